// ===== verilog/wit_pkg.sv
package wit_pkg;

  // Register bus geometry.
  localparam int          AXI_AW       = 18;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_CLK_SEL  = 16'hff42;
  localparam logic [15:0] IDX_MODE     = 16'hff4a;
  localparam logic [15:0] IDX_STATUS   = 16'hff50;
  localparam logic [15:0] IDX_IRQ_CLR  = 16'hff51;
  localparam logic [15:0] IDX_IRQ_EN   = 16'hff52;
  localparam logic [15:0] IDX_OSC_MODE = 16'hff53;

  // Reset values and writable bits.
  localparam logic [7:0]  CLK_SEL_RST  = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [7:0]  CLK_SEL_WMSK = 8'hf7;
  localparam logic [7:0]  MODE_WMSK    = 8'h7f;

  // Clock-select fields.
  localparam int          CS_WDT_LSB   = 0;
  localparam int          CS_SRC_BIT   = 4;
  localparam int          CS_BUZ_LSB   = 5;
  localparam int          CS_BUZ_EN    = 7;

  // Mode-control fields.
  localparam int          MD_FAST      = 0;
  localparam int          MD_PRUN      = 1;
  localparam int          MD_CRUN      = 2;
  localparam int          MD_SET       = 3;
  localparam int          MD_INT_LSB   = 4;

  // Status, clear and enable bit positions.
  localparam int          ST_OVF       = 0;
  localparam int          ST_INT       = 1;

  // Divider exponents and counter widths.
  localparam int          MAIN_DIV_W   = 11;
  localparam int          PRESC_W      = 9;
  localparam int          CNT5_W       = 5;
  localparam logic [3:0]  WDT_LOG2_LO  = 4'h3;
  localparam logic [3:0]  WDT_LOG2_TOP = 4'hb;
  localparam logic [3:0]  WATCH_LOG2   = 4'h7;
  localparam logic [3:0]  BUZ_LOG2_LO  = 4'h9;
  localparam logic [3:0]  INT_LOG2_LO  = 4'h4;
  localparam logic [3:0]  FF_LOG2      = 4'h5;
  localparam logic [3:0]  PRESC_LOG2   = 4'h9;
  localparam logic [2:0]  INT_CODE_MAX = 3'h5;
  localparam logic [1:0]  BUZ_CODE_BAD = 2'h3;

endpackage : wit_pkg

// ===== verilog/wit_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wit_cnt_if #(parameter int W = 8) ();
  logic         en;
  logic         clr;
  logic [W-1:0] cnt;
  modport ctl  (output en, output clr, input cnt);
  modport core (input en, input clr, output cnt);
endinterface : wit_cnt_if
`default_nettype wire

// ===== verilog/wit_div_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wit_div_counter
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Count control and value
  wit_cnt_if.core   bus
);
  import wit_pkg::*;

  // Clear dominates count so a stopped stage is zero one edge later.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || bus.clr)
      bus.cnt <= '0;
    else if (bus.en)
      bus.cnt <= bus.cnt + 1'b1;
  end

endmodule : wit_div_counter
`default_nettype wire

// ===== verilog/wit_pow2_tick.sv
`timescale 1ns/1ps
`default_nettype none
module wit_pow2_tick #(parameter int W = 8)
(
  // Counter state
  input  wire logic [W-1:0] cnt,
  input  wire logic         step,
  // Selection
  input  wire logic [3:0]   log2n,
  input  wire logic         valid,
  // Result
  output logic              tick
);
  import wit_pkg::*;

  logic [W-1:0] mask;

  always_comb
  begin
    mask = '0;
    for (int i = 0; i < W; i++)
      mask[i] = (i < int'(log2n));
  end

  // The last step of every 2^n block of steps.
  assign tick = step && valid && ((cnt & mask) == mask);

endmodule : wit_pow2_tick
`default_nettype wire

// ===== verilog/wit_watch_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Watch overflow and prescaler interval run together, independently.
// - Watchdog count tick is main clock over 2^3..2^9, code 7 gives 2^11.
// - Watch source bit picks main clock over 2^7 or subsystem clock.
// - Buzzer off unless top bit set; 2^9, 2^10, 2^11; code 111 silent.
// - Main clock equals oscillator when bypass bit set, else half of it.
// - Fast-forward bit sets the flag every 2^5 instead of 2^14 or 2^13 periods.
// - Prescaler counts while its run bit is set, else stops and clears.
// - Five-bit counter counts while its run bit is set, else clears.
// - Set-time bit gives overflow after 2^14 or 2^13 watch periods.
// - Interval field gives 2^4..2^9 watch periods; codes 6 and 7 silent.
// - Watch clock is main over 2^7 or the subsystem oscillator.
// - Each watch overflow sets a sticky flag that software clears.
// - Each selected prescaler interval raises an interval request.
module wit_watch_timer
(
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic [wit_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [wit_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Subsystem oscillator, one pulse per oscillator period
  input  wire logic                        sub_osc_tick,
  // Timer outputs
  output logic                             wdt_count_tick,
  output logic                             buzzer_out,
  output logic                             interval_pulse,
  output logic                             irq
);
  import wit_pkg::*;

  // Software-visible state.
  logic [7:0]              clk_sel;
  logic [7:0]              mode;
  logic [1:0]              irq_en;
  logic [1:0]              status;
  logic                    main_div_bypass;

  // Bus channel state, and the toggle that halves the main clock.
  logic                    aw_full;
  logic                    w_full;
  logic [AXI_AW-1:0]       aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    half;

  // Field views.
  wire logic [2:0] wdt_sel       = clk_sel[CS_WDT_LSB +: 3];
  wire logic       watch_src_sel = clk_sel[CS_SRC_BIT];
  wire logic [1:0] buz_lo        = clk_sel[CS_BUZ_LSB +: 2];
  wire logic       buzzer_enable = clk_sel[CS_BUZ_EN];
  wire logic       fast_fwd_sel  = mode[MD_FAST];
  wire logic       prescaler_run = mode[MD_PRUN];
  wire logic       counter5_run  = mode[MD_CRUN];
  wire logic       set_time_sel  = mode[MD_SET];
  wire logic [2:0] interval_sel  = mode[MD_INT_LSB +: 3];

  // The main clock steps every edge in bypass and every other edge
  // otherwise, so the watchdog, watch and buzzer taps below see the same main clock.
  wire logic main_tick = main_div_bypass || half;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      half <= 1'b0;
    else
      half <= ~half;
  end

  // Main clock divider shared by watchdog, buzzer and watch source.
  wit_cnt_if #(.W(MAIN_DIV_W)) main_if ();
  assign main_if.en  = main_tick;
  assign main_if.clr = 1'b0;

  wit_div_counter u_main_div
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (main_if.core)
  );

  // Code 7 jumps to 2^11; the others step up from 2^3.
  wire logic [3:0] wdt_log2 = (wdt_sel == 3'h7) ? WDT_LOG2_TOP
                            : WDT_LOG2_LO + {1'b0, wdt_sel};
  logic            wdt_tick;

  wit_pow2_tick #(.W(MAIN_DIV_W)) u_wdt_tick
  (
    .cnt   (main_if.cnt),
    .step  (main_tick),
    .log2n (wdt_log2),
    .valid (1'b1),
    .tick  (wdt_tick)
  );

  logic            main_watch_tick;

  wit_pow2_tick #(.W(MAIN_DIV_W)) u_watch_main
  (
    .cnt   (main_if.cnt),
    .step  (main_tick),
    .log2n (WATCH_LOG2),
    .valid (1'b1),
    .tick  (main_watch_tick)
  );

  // Watch clock source.
  wire logic watch_tick = watch_src_sel ? sub_osc_tick : main_watch_tick;

  // Buzzer square wave: bit n-1 of the divider has period 2^n.
  wire logic [3:0] buz_log2 = BUZ_LOG2_LO + {2'b00, buz_lo};
  wire logic       buz_ok   = buzzer_enable && (buz_lo != BUZ_CODE_BAD);
  wire logic       buz_wave = main_if.cnt[buz_log2 - 4'h1];

  // Prescaler; a cleared run bit holds it at zero.
  wit_cnt_if #(.W(PRESC_W)) presc_if ();
  assign presc_if.en  = watch_tick && prescaler_run;
  assign presc_if.clr = !prescaler_run;

  wit_div_counter u_presc
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (presc_if.core)
  );

  logic            presc_carry;

  wit_pow2_tick #(.W(PRESC_W)) u_presc_carry
  (
    .cnt   (presc_if.cnt),
    .step  (presc_if.en),
    .log2n (PRESC_LOG2),
    .valid (1'b1),
    .tick  (presc_carry)
  );

  // Interval taps 2^4..2^9 run beside the watch chain.
  wire logic [3:0] int_log2 = INT_LOG2_LO + {1'b0, interval_sel};
  wire logic       int_ok   = interval_sel <= INT_CODE_MAX;
  logic            interval_tick;

  wit_pow2_tick #(.W(PRESC_W)) u_int_tick
  (
    .cnt   (presc_if.cnt),
    .step  (presc_if.en),
    .log2n (int_log2),
    .valid (int_ok),
    .tick  (interval_tick)
  );

  logic            ff_tick;

  wit_pow2_tick #(.W(PRESC_W)) u_ff_tick
  (
    .cnt   (presc_if.cnt),
    .step  (presc_if.en),
    .log2n (FF_LOG2),
    .valid (1'b1),
    .tick  (ff_tick)
  );

  // Five-bit counter takes the prescaler carry.
  wit_cnt_if #(.W(CNT5_W)) cnt5_if ();
  assign cnt5_if.en  = presc_carry && counter5_run;
  assign cnt5_if.clr = !counter5_run;

  wit_div_counter u_cnt5
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (cnt5_if.core)
  );

  // 2^9 x 32 = 2^14, or 2^9 x 16 = 2^13 periods.
  wire logic cnt5_last = set_time_sel ? (cnt5_if.cnt[3:0] == 4'hf)
                                      : (cnt5_if.cnt == 5'h1f);
  wire logic ovf_norm  = cnt5_if.en && cnt5_last;
  // Fast-forward still needs the counter enabled so both run bits
  // keep their meaning in either mode.
  wire logic ovf_event = fast_fwd_sel ? (ff_tick && counter5_run)
                                      : ovf_norm;

  // Registered timer outputs.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdt_count_tick <= 1'b0;
      interval_pulse <= 1'b0;
      buzzer_out     <= 1'b0;
    end
    else
    begin
      wdt_count_tick <= wdt_tick;
      interval_pulse <= interval_tick;
      buzzer_out     <= buz_ok && buz_wave;
    end
  end

  // Write path: address and data are held until both have arrived.
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  wire logic aw_take   = s_axi_awvalid && s_axi_awready;
  wire logic w_take    = s_axi_wvalid && s_axi_wready;
  wire logic wr_go     = aw_full && w_full && !s_axi_bvalid;

  wire logic [15:0] wr_idx    = aw_addr[AXI_AW-1:2];
  wire logic        wr_lane   = wr_go && w_strb[0];
  wire logic        wr_clksel = wr_idx == IDX_CLK_SEL;
  wire logic        wr_mode   = wr_idx == IDX_MODE;
  wire logic        wr_clr    = wr_idx == IDX_IRQ_CLR;
  wire logic        wr_en     = wr_idx == IDX_IRQ_EN;
  wire logic        wr_osc    = wr_idx == IDX_OSC_MODE;
  wire logic        wr_hit    = wr_clksel || wr_mode || wr_clr || wr_en
                              || wr_osc || (wr_idx == IDX_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end
    else if (aw_take)
    begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_full <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (w_take)
    begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_go)
      w_full <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // A new clock selection applies at once; keeping the counters quiet
  // across it is the writer's job, not this logic's.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_sel         <= CLK_SEL_RST;
      mode            <= MODE_RST;
      irq_en          <= 2'h0;
      main_div_bypass <= 1'b0;
    end
    else if (wr_lane)
    begin
      if (wr_clksel)
        clk_sel <= w_data[7:0] & CLK_SEL_WMSK;
      if (wr_mode)
        mode <= w_data[7:0] & MODE_WMSK;
      if (wr_en)
        irq_en <= w_data[1:0];
      if (wr_osc)
        main_div_bypass <= w_data[0];
    end
  end

  // Sticky events; a set in the same cycle as its clear survives.
  wire logic [1:0] st_set = {interval_tick, ovf_event};
  wire logic [1:0] st_clr = (wr_lane && wr_clr) ? w_data[1:0] : 2'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= 2'h0;
    else
      status <= (status & ~st_clr) | st_set;
  end

  assign irq = |(status & irq_en);

  // Read path: one word answered on the edge after the address.
  assign s_axi_arready = !s_axi_rvalid;
  wire logic        ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [15:0] rd_idx  = s_axi_araddr[AXI_AW-1:2];
  wire logic        rd_hit  = (rd_idx == IDX_CLK_SEL) || (rd_idx == IDX_MODE)
                            || (rd_idx == IDX_STATUS) || (rd_idx == IDX_IRQ_CLR)
                            || (rd_idx == IDX_IRQ_EN)
                            || (rd_idx == IDX_OSC_MODE);
  wire logic [7:0]  rd_byte =
      (rd_idx == IDX_CLK_SEL)  ? clk_sel :
      (rd_idx == IDX_MODE)     ? mode :
      (rd_idx == IDX_STATUS)   ? {6'h00, status} :
      (rd_idx == IDX_IRQ_EN)   ? {6'h00, irq_en} :
      (rd_idx == IDX_OSC_MODE) ? {7'h00, main_div_bypass} : 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wdt_cfg0;
    (wdt_sel == 3'h0) && main_div_bypass && !wr_go;
  endsequence

  chk_wdt_div8: assert property (
    (wdt_tick and s_wdt_cfg0) ##1 s_wdt_cfg0 [*7] |=> wdt_tick)
    else $error("watchdog tick not at main clock over 8");

  chk_main_half: assert property (
    (!main_div_bypass && main_tick) |=> main_div_bypass || !main_tick)
    else $error("divided main clock stepped twice in a row");

  chk_watch_src: assert property (
    (watch_src_sel && !sub_osc_tick) |-> !presc_if.en)
    else $error("prescaler stepped without a subsystem tick");

  chk_presc_stop: assert property (
    !prescaler_run |=> (presc_if.cnt == '0))
    else $error("stopped prescaler not cleared");

  chk_cnt5_stop: assert property (
    !counter5_run |=> (cnt5_if.cnt == '0))
    else $error("stopped five-bit counter not cleared");

  chk_set_time13: assert property (
    (ovf_event && !fast_fwd_sel && set_time_sel)
      |-> (cnt5_if.cnt[3:0] == 4'hf) && (presc_if.cnt == 9'h1ff))
    else $error("short set time overflow at wrong count");

  chk_fast_fwd: assert property (
    (ovf_event && fast_fwd_sel) |-> (presc_if.cnt[4:0] == 5'h1f))
    else $error("fast-forward flag not at 2^5 boundary");

  chk_int_prohib: assert property (
    (interval_sel > INT_CODE_MAX) |-> !interval_tick)
    else $error("interval tick under prohibited code");

  chk_int_pulse: assert property (
    interval_tick |=> interval_pulse && status[ST_INT])
    else $error("interval tick not reported");

  chk_ovf_flag: assert property (
    ovf_event |=> status[ST_OVF] ##1 (status[ST_OVF] || $past(st_clr[0])))
    else $error("overflow flag not set or lost");

  chk_buz_off: assert property (
    (!buzzer_enable || (buz_lo == BUZ_CODE_BAD)) |=> !buzzer_out)
    else $error("buzzer active while disabled");

  chk_rsvd_bits: assert property (
    !clk_sel[3] && !mode[7])
    else $error("reserved configuration bit set");

endmodule : wit_watch_timer
`default_nettype wire

// ===== sim/wit_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  import wit_pkg::*;
  typedef struct {
    logic [15:0] idx;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [1:0]  wr;
    logic [1:0]  rr;
  } wit_row_s;
  logic              aclk;
  logic              aresetn;
  logic [AXI_AW-1:0] awaddr;
  logic [AXI_AW-1:0] araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp, r;
  logic [7:0]        d;
  logic              sub_osc_tick, wdt_tick, buz, ipulse, irq;
  int                n_mismatch, checked, cyc, sub_per, sc, g, h;
  wit_row_s          rows [7] = '{
    '{IDX_STATUS,   8'hff, 8'h00, RESP_OKAY,   RESP_OKAY},
    '{IDX_IRQ_CLR,  8'hff, 8'h00, RESP_OKAY,   RESP_OKAY},
    '{IDX_IRQ_EN,   8'hff, 8'h03, RESP_OKAY,   RESP_OKAY},
    '{IDX_OSC_MODE, 8'h01, 8'h01, RESP_OKAY,   RESP_OKAY},
    '{16'h0010,     8'h5a, 8'h00, RESP_SLVERR, RESP_SLVERR},
    '{IDX_CLK_SEL,  8'hff, 8'hf7, RESP_OKAY,   RESP_OKAY},
    '{IDX_MODE,     8'hff, 8'h7f, RESP_OKAY,   RESP_OKAY}};

  wit_watch_timer i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sub_osc_tick(sub_osc_tick),
    .wdt_count_tick(wdt_tick), .buzzer_out(buz), .interval_pulse(ipulse),
    .irq(irq));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Subsystem oscillator stand-in; a period of one cycle holds it high.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    sc <= (sc + 1 >= sub_per) ? 0 : sc + 1;
    sub_osc_tick <= (sub_per != 0) && (sc == 0);
  end

  task test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task die;
    n_mismatch++;
    test_done;
  endtask : die

  // Handshakes are judged at the falling edge, where every input and the
  // combinational readies are settled, and acted on at the next rising edge.
  task axi_wr(input logic [15:0] idx, input logic [7:0] v,
              output logic [1:0] rs);
    int  n;
    bit  a, w, b;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    b = 0;
    while (!b)
    begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      if (++n > 200) die;
    end
  endtask : axi_wr

  task axi_rd(input logic [15:0] idx, output logic [7:0] v,
              output logic [1:0] rs);
    int  n;
    bit  a, b;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    b = 0;
    while (!b)
    begin
      @(negedge aclk);
      a = arvalid && arready;
      b = rvalid && rready;
      v = rdata[7:0];
      rs = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (b) rready <= 1'b0;
      if (++n > 200) die;
    end
  endtask : axi_rd

  function automatic logic pick(input int s);
    case (s)
      0: return wdt_tick;
      1: return buz;
      2: return ipulse;
      default: return irq;
    endcase
  endfunction : pick

  // Cycles between two rising edges of the chosen output. For the interrupt
  // the status is cleared before each edge, so the level can rise again.
  task gap_of(input int s, input int lim, output int gp);
    int n, t0;
    if (s == 3) axi_wr(IDX_IRQ_CLR, 8'h03, r);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      while (pick(s) !== 1'b0 && n < lim) begin @(negedge aclk); n++; end
      while (pick(s) !== 1'b1 && n < lim) begin @(negedge aclk); n++; end
      if (n >= lim) die;
      if (k == 0) t0 = cyc;
      else gp = cyc - t0;
      if (s == 3 && k == 0) axi_wr(IDX_IRQ_CLR, 8'h03, r);
    end
  endtask : gap_of

  task quiet(input int s, input int len, output int hits);
    hits = 0;
    repeat (len)
    begin
      @(negedge aclk);
      if (pick(s) !== 1'b0) hits++;
    end
  endtask : quiet

  task do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    {cyc, sc, sub_per, n_mismatch, checked} = '0;
    do_reset;
    foreach (rows[i])
    begin
      axi_wr(rows[i].idx, rows[i].wd, r);
      `CHK("wresp", rows[i].wr, r)
      axi_rd(rows[i].idx, d, r);
      `CHK("rdata", rows[i].rd, d)
      `CHK("rresp", rows[i].rr, r)
    end
    do_reset;
    axi_rd(IDX_CLK_SEL, d, r);
    `CHK("clk_sel_rst", CLK_SEL_RST, d)
    axi_rd(IDX_MODE, d, r);
    `CHK("mode_rst", MODE_RST, d)
    quiet(1, 3000, h);
    `CHK("buz_rst", 0, h)
    gap_of(0, 200, g);
    `CHK("wdt_div2", 16, g)
    axi_wr(IDX_OSC_MODE, 8'h01, r);
    for (int c = 0; c < 8; c++)
    begin
      axi_wr(IDX_CLK_SEL, 8'(c), r);
      gap_of(0, 5000, g);
      `CHK("wdt_gap", (c == 7) ? 2048 : (8 << c), g)
    end
    for (int c = 0; c < 3; c++)
    begin
      axi_wr(IDX_CLK_SEL, 8'h80 | 8'(c << 5), r);
      gap_of(1, 6000, g);
      `CHK("buz_gap", 512 << c, g)
    end
    axi_wr(IDX_CLK_SEL, 8'he0, r);
    quiet(1, 5000, h);
    `CHK("buz_bad", 0, h)
    axi_wr(IDX_CLK_SEL, 8'h60, r);
    quiet(1, 5000, h);
    `CHK("buz_off", 0, h)
    axi_wr(IDX_MODE, 8'h02, r);
    gap_of(2, 6000, g);
    `CHK("int_main_src", 2048, g)
    sub_per = 4;
    axi_wr(IDX_MODE, 8'h00, r);
    axi_wr(IDX_CLK_SEL, 8'h10, r);
    for (int c = 0; c < 7; c++)
    begin
      axi_wr(IDX_MODE, 8'(c << 4) | 8'h02, r);
      if (c < 6) gap_of(2, 6000, g);
      else quiet(2, 4000, g);
      `CHK("int_gap", (c < 6) ? (64 << c) : 0, g)
    end
    axi_wr(IDX_MODE, 8'h00, r);
    quiet(2, 300, h);
    `CHK("presc_stop", 0, h)
    sub_per = 1;
    axi_wr(IDX_IRQ_EN, 8'h01, r);
    axi_wr(IDX_MODE, 8'h03, r);
    axi_wr(IDX_IRQ_CLR, 8'h03, r);
    quiet(3, 300, h);
    `CHK("cnt_stop", 0, h)
    axi_wr(IDX_MODE, 8'h07, r);
    gap_of(3, 300, g);
    `CHK("fast_gap", 32, g)
    axi_wr(IDX_MODE, 8'h0e, r);
    gap_of(3, 20000, g);
    `CHK("set_gap", 8192, g)
    axi_wr(IDX_MODE, 8'h06, r);
    gap_of(3, 40000, g);
    `CHK("norm_gap", 16384, g)
    axi_wr(IDX_IRQ_EN, 8'h00, r);
    @(negedge aclk);
    `CHK("irq_mask", 1'b0, irq)
    axi_rd(IDX_STATUS, d, r);
    `CHK("ovf_sticky", 8'h01, d & 8'h01)
    `CHK("int_flag", 8'h02, d & 8'h02)
    axi_wr(IDX_MODE, 8'h00, r);
    axi_wr(IDX_IRQ_CLR, 8'h03, r);
    axi_rd(IDX_STATUS, d, r);
    `CHK("status_clr", 8'h00, d)
    test_done;
  end
endmodule : testbench
`default_nettype wire
